// ### design/dxjs_timer.sv
// dxjs_timer: bank of one-shot timers, one per supervised interval.
// assumes start wins over stop; fire is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module dxjs_timer import dxjs_pkg::*; #(
   parameter int N = DXJS_NTMR,
   parameter int W = DXJS_TMR_W
) (
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   input  wire logic clk_en_i,
   // timer lines
   dxjs_tmr_if.tmr   t
);
   if (N < 1 || W < 1) begin : g_bad
      $error("dxjs_timer: parameter out of range");
   end

   for (genvar i = 0; i < N; i++) begin : g_ch
      logic [W-1:0] cnt_q;
      logic         armed_q;

      // fires limit edges after the start edge
      assign t.fire[i] = armed_q && (cnt_q == t.limit[i]);

      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            cnt_q   <= '0;
            armed_q <= 1'b0;
         end else if (clk_en_i) begin
            if (t.start[i]) begin
               cnt_q   <= '0;
               armed_q <= 1'b1;
            end else if (t.stop[i] || t.fire[i]) begin
               armed_q <= 1'b0;
            end else if (armed_q) begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### design/dxjs_top.sv
// dxjs_top: duplex reversal sequencing and paper path jam supervision.
// assumes pins are asynchronous, formatter and link logic share ref_clk_i.
// What this block does
// RULE_01 - reversing command sent set delay after top-of-page leading edge
// RULE_02 - driver energises deflector, runs reversal motor clockwise on reverse
// RULE_03 - duplex pickup command sent set delay after fuser trailing edge
// RULE_04 - driver runs reversal motor counterclockwise on duplex pickup
// RULE_05 - driver moves loads only on command and reports status back
// RULE_06 - one, two or three sheets in flight; multi-sheet refused for legal (code refuses it for duplex only; simplex legal runs three)
// RULE_07 - duplex jobs refused outside permitted sizes and print modes
// RULE_08 - missed sensor window stops all motors and flags a jam
// RULE_09 - pickup retried before jam; four attempts for the manual tray
// RULE_10 - pickup delay jam when top-of-page misses leading edge in time
// RULE_11 - pickup stationary jam when top-of-page stays active too long
// RULE_12 - delivery delay jam when fuser misses leading edge after top-of-page
// RULE_13 - door open jam when any cover or door opens while printing
// RULE_14 - residual jam: fuser active in wait or interval, or path after delivery
// RULE_15 - reversing jam 1 when reversal sensor misses edge after command
// RULE_16 - reversing jam 2 when reversal sensor stays active too long
// RULE_17 - duplex pickup jam 1 when top-of-page misses edge after command
// RULE_18 - top-of-page in wait halts, notifies; automatic delivery ejects on command
// RULE_19 - every command delay and jam timeout is its own cycle count
`timescale 1ns/1ps
`default_nettype none
module dxjs_top import dxjs_pkg::*; #(
   parameter int NDOOR      = 5,
   parameter int TW         = DXJS_TMR_W,
   parameter int REVC_CYC   = DXJS_REVC_CYC,
   parameter int DPKC_CYC   = DXJS_DPKC_CYC,
   parameter int PICK_CYC   = DXJS_PICK_CYC,
   parameter int STAY_CYC   = DXJS_STAY_CYC,
   parameter int DELV_CYC   = DXJS_DELV_CYC,
   parameter int REV1_CYC   = DXJS_REV1_CYC,
   parameter int REV2_CYC   = DXJS_REV2_CYC,
   parameter int DPK1_CYC   = DXJS_DPK1_CYC,
   parameter int AUTO_CYC   = DXJS_AUTO_CYC,
   parameter int RETRY_TRAY = DXJS_RETRY_TRAY
) (
   // clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             clk_en_i,
   // paper path sensors and doors, asynchronous
   input  wire logic             top_of_page_sensor_i,
   input  wire logic             fuser_exit_sensor_i,
   input  wire logic             output_tray_full_sensor_i,
   input  wire logic             reversal_path_sensor_i,
   input  wire logic [NDOOR-1:0] door_open_i,
   // formatter
   input  wire logic             job_start_i,
   input  wire logic             job_stop_i,
   input  wire logic [2:0]       paper_size_i,
   input  wire logic [2:0]       print_mode_i,
   input  wire logic [1:0]       duplex_mode_i,
   input  wire logic [1:0]       pickup_source_i,
   input  wire logic             page_req_i,
   input  wire logic             auto_deliver_i,
   input  wire logic             jam_clear_i,
   output logic                  job_reject_o,
   output logic                  residual_o,
   output logic                  tray_full_o,
   output logic                  interpage_phase_o,
   output logic                  jam_o,
   output logic [3:0]            jam_code_o,
   // engine
   output logic                  motors_run_o,
   output logic                  pickup_o,
   // duplex driver link
   output logic                  dup_cmd_valid_o,
   output logic                  dup_cmd_kind_o,
   input  wire logic             dup_cmd_ready_i,
   input  wire logic             dup_status_valid_i,
   input  wire logic [7:0]       dup_status_i,
   output logic [7:0]            dup_status_o
);
   localparam int NS = DXJS_NSENS + NDOOR;

   if (NDOOR < 1 || TW < 4 || RETRY_TRAY < 1 || RETRY_TRAY > 15 || REVC_CYC < 1 ||
       DPKC_CYC < 1 || PICK_CYC < 1 || STAY_CYC < 1 || DELV_CYC < 1 || REV1_CYC < 1 ||
       REV2_CYC < 1 || DPK1_CYC < 1 || AUTO_CYC < 1) begin : g_bad
      $error("dxjs_top: parameter out of range");
   end

   function automatic logic job_ok(input logic [2:0] sz, input logic [2:0] pm,
                                   input logic [1:0] dm);
      logic sz_ok;
      sz_ok = (sz <= DXJS_SZ_B5);
      if (dm == DXJS_DM_SIMPLEX) return 1'b1;
      return sz_ok && (pm <= DXJS_PM_LAST_DUP) &&
             !(sz == DXJS_SZ_LEGAL && dm != DXJS_DM_SINGLE);
   endfunction

   // three-flop synchroniser; a change counts once flops two and three agree
   logic [NS-1:0] s1_q, s2_q, s3_q, filt_q, prev_q;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q   <= '0;
         s2_q   <= '0;
         s3_q   <= '0;
         filt_q <= '0;
         prev_q <= '0;
      end else if (clk_en_i) begin
         s1_q   <= {door_open_i, reversal_path_sensor_i, output_tray_full_sensor_i,
                    fuser_exit_sensor_i, top_of_page_sensor_i};
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
         prev_q <= filt_q;
      end
   end

   wire logic [NS-1:0] rise = filt_q & ~prev_q;
   wire logic [NS-1:0] fall = ~filt_q & prev_q;
   wire logic top  = filt_q[DXJS_IDX_TOP];
   wire logic fus  = filt_q[DXJS_IDX_FUSER];
   wire logic door = |filt_q[NS-1:DXJS_NSENS];

   dxjs_tmr_if #(.N(DXJS_NTMR), .W(TW)) tmr ();
   dxjs_timer #(.N(DXJS_NTMR), .W(TW)) u_tmr (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .clk_en_i  (clk_en_i),
      .t         (tmr.tmr)
   );

   // each interval has its own count [RULE_19]
   assign tmr.limit = {TW'(AUTO_CYC), TW'(DPK1_CYC), TW'(REV2_CYC), TW'(REV1_CYC),
                       TW'(DELV_CYC), TW'(STAY_CYC), TW'(PICK_CYC), TW'(DPKC_CYC),
                       TW'(REVC_CYC)};

   dxjs_state_t st_q;
   logic        dup_job_q, stop_q, picking_q, pend_q, rev_sent_q, dup_feed_q;
   logic        rev_due_q, dpk_due_q, cmd_valid_q, cmd_kind_q;
   logic [1:0]  flight_q, flight_lim_q, src_q;
   logic [3:0]  tries_q;
   logic        jam_hit, pick_new, pick_retry;
   logic [3:0]  jam_code;

   wire logic [3:0] retry_lim = (src_q == DXJS_SRC_MANUAL) ? DXJS_RETRY_MANUAL :
                                4'(RETRY_TRAY);
   wire logic pick_fire = tmr.fire[DXJS_T_PICK];
   wire logic cmd_acc   = cmd_valid_q && dup_cmd_ready_i;
   wire logic in_print  = (st_q == DXJS_S_PRINT);

   // fresh pickup only while the mode's sheet count allows [RULE_06]
   assign pick_new   = in_print && (pend_q || page_req_i) && !picking_q && !stop_q &&
                       (flight_q < flight_lim_q) && !filt_q[DXJS_IDX_FULL];
   assign pick_retry = in_print && pick_fire && (tries_q < retry_lim); // [RULE_09]

   always_comb begin
      tmr.start = '0;
      tmr.stop  = '1;
      jam_hit   = 1'b0;
      jam_code  = DXJS_J_NONE;
      unique case (st_q)
         DXJS_S_PRINT: begin
            tmr.stop = '0;
            if (pick_new || pick_retry) tmr.start[DXJS_T_PICK] = 1'b1;
            if (rise[DXJS_IDX_TOP]) begin
               tmr.stop[DXJS_T_PICK]  = 1'b1;
               tmr.stop[DXJS_T_DPK1]  = 1'b1;
               tmr.start[DXJS_T_STAY] = 1'b1;
               tmr.start[DXJS_T_DELV] = 1'b1;
               if (dup_job_q && !dup_feed_q) tmr.start[DXJS_T_REVC] = 1'b1; // [RULE_01]
            end
            if (fall[DXJS_IDX_TOP])   tmr.stop[DXJS_T_STAY] = 1'b1;
            if (rise[DXJS_IDX_FUSER]) tmr.stop[DXJS_T_DELV] = 1'b1;
            if (fall[DXJS_IDX_FUSER] && rev_sent_q) tmr.start[DXJS_T_DPKC] = 1'b1; // [RULE_03]
            if (rise[DXJS_IDX_REV]) begin
               tmr.stop[DXJS_T_REV1]  = 1'b1;
               tmr.start[DXJS_T_REV2] = 1'b1;
            end
            if (fall[DXJS_IDX_REV]) tmr.stop[DXJS_T_REV2] = 1'b1;
            if (cmd_acc) tmr.start[cmd_kind_q ? DXJS_T_DPK1 : DXJS_T_REV1] = 1'b1;
            jam_hit = 1'b1;
            if (door)                                  jam_code = DXJS_J_DOOR;  // [RULE_13]
            else if (pick_fire && !pick_retry)         jam_code = DXJS_J_PICK;  // [RULE_10]
            else if (tmr.fire[DXJS_T_STAY])            jam_code = DXJS_J_STAY;  // [RULE_11]
            else if (tmr.fire[DXJS_T_DELV])            jam_code = DXJS_J_DELV;  // [RULE_12]
            else if (tmr.fire[DXJS_T_REV1])            jam_code = DXJS_J_REV1;  // [RULE_15]
            else if (tmr.fire[DXJS_T_REV2])            jam_code = DXJS_J_REV2;  // [RULE_16]
            else if (tmr.fire[DXJS_T_DPK1])            jam_code = DXJS_J_DPK1;  // [RULE_17]
            else if (fus && flight_q == 2'h0)          jam_code = DXJS_J_RESID; // [RULE_14]
            else jam_hit = 1'b0;
         end
         DXJS_S_WAIT, DXJS_S_HALT: begin
            if (fus) begin
               jam_hit  = 1'b1;
               jam_code = DXJS_J_RESID; // [RULE_14]
            end
            if (st_q == DXJS_S_HALT && auto_deliver_i) begin
               tmr.stop[DXJS_T_AUTO]  = 1'b0;
               tmr.start[DXJS_T_AUTO] = 1'b1; // [RULE_18]
            end
         end
         DXJS_S_AUTO: begin
            tmr.stop[DXJS_T_AUTO] = 1'b0;
            if (door) begin
               jam_hit  = 1'b1;
               jam_code = DXJS_J_DOOR; // [RULE_13]
            end else if (tmr.fire[DXJS_T_AUTO] && (top || fus)) begin
               jam_hit  = 1'b1;
               jam_code = DXJS_J_RESID; // [RULE_14]
            end
         end
         DXJS_S_JAM: ;
         default: ;
      endcase
   end

   // phase sequencing
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q         <= DXJS_S_WAIT;
         jam_code_o   <= DXJS_J_NONE;
         job_reject_o <= 1'b0;
         dup_job_q    <= 1'b0;
         flight_lim_q <= DXJS_DM_SINGLE;
         src_q        <= DXJS_SRC_MANUAL;
         stop_q       <= 1'b0;
      end else if (clk_en_i) begin
         job_reject_o <= 1'b0;
         if (jam_hit) begin
            st_q       <= DXJS_S_JAM; // [RULE_08]
            jam_code_o <= jam_code;
         end else begin
            unique case (st_q)
               DXJS_S_WAIT: begin
                  stop_q <= 1'b0;
                  if (top) begin
                     st_q <= DXJS_S_HALT; // [RULE_18]
                  end else if (job_start_i) begin
                     if (job_ok(paper_size_i, print_mode_i, duplex_mode_i)) begin // [RULE_07]
                        st_q         <= DXJS_S_PRINT;
                        dup_job_q    <= (duplex_mode_i != DXJS_DM_SIMPLEX);
                        flight_lim_q <= (duplex_mode_i == DXJS_DM_SIMPLEX) ?
                                        DXJS_SIMPLEX_FLIGHT : duplex_mode_i; // [RULE_06]
                        src_q        <= pickup_source_i;
                     end else begin
                        job_reject_o <= 1'b1; // [RULE_06]
                     end
                  end
               end
               DXJS_S_PRINT: begin
                  if (job_stop_i) stop_q <= 1'b1;
                  if ((stop_q || job_stop_i) && flight_q == 2'h0 && !picking_q)
                     st_q <= DXJS_S_WAIT;
               end
               DXJS_S_HALT: if (auto_deliver_i) st_q <= DXJS_S_AUTO;
               DXJS_S_AUTO: if (tmr.fire[DXJS_T_AUTO]) st_q <= DXJS_S_WAIT;
               DXJS_S_JAM: begin
                  if (jam_clear_i && !door && !top && !fus) begin
                     st_q       <= DXJS_S_WAIT;
                     jam_code_o <= DXJS_J_NONE;
                  end
               end
               default: st_q <= DXJS_S_JAM;
            endcase
         end
      end
   end

   // pickup and sheet accounting; a sheet leaves at the fuser unless reversed
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pickup_o   <= 1'b0;
         pend_q     <= 1'b0;
         picking_q  <= 1'b0;
         tries_q    <= 4'h0;
         flight_q   <= 2'h0;
         rev_sent_q <= 1'b0;
         dup_feed_q <= 1'b0;
      end else if (clk_en_i) begin
         // a jam in the same cycle must not launch one more pickup [RULE_08]
         pickup_o <= (pick_new || pick_retry) && !jam_hit;
         if (!in_print) begin
            pend_q     <= 1'b0;
            picking_q  <= 1'b0;
            flight_q   <= 2'h0;
            rev_sent_q <= 1'b0;
            dup_feed_q <= 1'b0;
         end else begin
            pend_q <= (pend_q || page_req_i) && !pick_new;
            if (pick_new) begin
               picking_q <= 1'b1;
               tries_q   <= 4'h1;
            end else if (pick_retry) begin
               tries_q <= tries_q + 4'h1; // [RULE_09]
            end else if (rise[DXJS_IDX_TOP]) begin
               picking_q <= 1'b0;
            end
            flight_q <= flight_q + 2'(pick_new) -
                        2'(fall[DXJS_IDX_FUSER] && !rev_sent_q);
            if (cmd_acc && cmd_kind_q == DXJS_CMD_REV) rev_sent_q <= 1'b1;
            else if (fall[DXJS_IDX_FUSER]) rev_sent_q <= 1'b0;
            if (cmd_acc && cmd_kind_q == DXJS_CMD_DPK) dup_feed_q <= 1'b1;
            else if (rise[DXJS_IDX_TOP]) dup_feed_q <= 1'b0;
         end
      end
   end

   // driver link; a due flag set in the cycle it is loaded is kept
   wire logic load = !cmd_valid_q && (rev_due_q || dpk_due_q) && in_print;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rev_due_q    <= 1'b0;
         dpk_due_q    <= 1'b0;
         cmd_valid_q  <= 1'b0;
         cmd_kind_q   <= DXJS_CMD_REV;
         dup_status_o <= 8'h00;
      end else if (clk_en_i) begin
         rev_due_q <= in_print && ((rev_due_q && !load) || tmr.fire[DXJS_T_REVC]); // [RULE_01]
         dpk_due_q <= in_print && ((dpk_due_q && !(load && !rev_due_q)) ||
                      tmr.fire[DXJS_T_DPKC]); // [RULE_03]
         if (load) begin
            cmd_valid_q <= 1'b1;
            cmd_kind_q  <= rev_due_q ? DXJS_CMD_REV : DXJS_CMD_DPK;
         end else if (cmd_acc || !in_print) begin
            cmd_valid_q <= 1'b0;
         end
         if (dup_status_valid_i) dup_status_o <= dup_status_i; // [RULE_05]
      end
   end

   assign dup_cmd_valid_o   = cmd_valid_q;
   assign dup_cmd_kind_o    = cmd_kind_q;
   assign jam_o             = (st_q == DXJS_S_JAM);
   assign motors_run_o      = in_print || (st_q == DXJS_S_AUTO); // [RULE_08]
   assign residual_o        = (st_q == DXJS_S_HALT); // [RULE_18]
   assign tray_full_o       = filt_q[DXJS_IDX_FULL];
   assign interpage_phase_o = in_print && (flight_q == 2'h0);

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_reject_job;
      clk_en_i && st_q == DXJS_S_WAIT && !top && !fus && job_start_i &&
      !job_ok(paper_size_i, print_mode_i, duplex_mode_i);
   endsequence
   sequence s_jam_entry;
      clk_en_i && jam_hit;
   endsequence

   AST_REV_CMD: assert property (clk_en_i && in_print && tmr.fire[DXJS_T_REVC] && !jam_hit // [RULE_01]
      |=> rev_due_q || (cmd_valid_q && cmd_kind_q == DXJS_CMD_REV))
      else $error("reverse command not queued after delay");
   AST_DPK_CMD: assert property (clk_en_i && in_print && tmr.fire[DXJS_T_DPKC] && !jam_hit // [RULE_03]
      |=> dpk_due_q || cmd_valid_q)
      else $error("duplex pickup command not queued after delay");
   AST_REJECT: assert property (s_reject_job |=> job_reject_o && st_q == DXJS_S_WAIT) // [RULE_07]
      else $error("bad duplex job not refused");
   AST_LEGAL: assert property (in_print && dup_job_q |-> flight_q <= flight_lim_q) // [RULE_06]
      else $error("more sheets in flight than mode allows");
   AST_JAM_STOP: assert property (s_jam_entry |=> jam_o && !motors_run_o && !pickup_o) // [RULE_08]
      else $error("jam did not stop transport");
   AST_RETRY: assert property (pickup_o |-> tries_q <= retry_lim) // [RULE_09]
      else $error("too many pickup attempts");
   AST_PICK_JAM: assert property (clk_en_i && in_print && !door && pick_fire && // [RULE_10]
      tries_q >= retry_lim |=> jam_o && jam_code_o == DXJS_J_PICK)
      else $error("pickup delay jam missed");
   AST_DOOR: assert property (clk_en_i && in_print && door |=> jam_code_o == DXJS_J_DOOR) // [RULE_13]
      else $error("door open jam missed");
   AST_RESID: assert property (clk_en_i && st_q == DXJS_S_WAIT && fus // [RULE_14]
      |=> jam_o && jam_code_o == DXJS_J_RESID)
      else $error("residual jam missed in wait");
   AST_HALT: assert property (clk_en_i && st_q == DXJS_S_WAIT && top && !fus // [RULE_18]
      |=> residual_o && !motors_run_o)
      else $error("residual paper did not halt");
endmodule
`default_nettype wire

// ### pkg/dxjs_pkg.sv
// dxjs_pkg: constants and types of the duplex and jam supervisor.
// assumes nothing; imported whole by every design file.
package dxjs_pkg;

   // sensor vector layout after the synchroniser, doors follow
   localparam int DXJS_NSENS     = 4;
   localparam int DXJS_IDX_TOP   = 0;
   localparam int DXJS_IDX_FUSER = 1;
   localparam int DXJS_IDX_FULL  = 2;
   localparam int DXJS_IDX_REV   = 3;

   // timer channels
   localparam int DXJS_NTMR   = 9;
   localparam int DXJS_T_REVC = 0;
   localparam int DXJS_T_DPKC = 1;
   localparam int DXJS_T_PICK = 2;
   localparam int DXJS_T_STAY = 3;
   localparam int DXJS_T_DELV = 4;
   localparam int DXJS_T_REV1 = 5;
   localparam int DXJS_T_REV2 = 6;
   localparam int DXJS_T_DPK1 = 7;
   localparam int DXJS_T_AUTO = 8;

   // default cycle counts at 200 MHz, 5 ns per cycle
   localparam int DXJS_TMR_W      = 16;
   localparam int DXJS_REVC_CYC   = 400;
   localparam int DXJS_DPKC_CYC   = 300;
   localparam int DXJS_PICK_CYC   = 1000;
   localparam int DXJS_STAY_CYC   = 2000;
   localparam int DXJS_DELV_CYC   = 1500;
   localparam int DXJS_REV1_CYC   = 800;
   localparam int DXJS_REV2_CYC   = 2000;
   localparam int DXJS_DPK1_CYC   = 1200;
   localparam int DXJS_AUTO_CYC   = 3000;

   // pickup attempts per source
   localparam logic [1:0] DXJS_SRC_MANUAL    = 2'h0;
   localparam logic [3:0] DXJS_RETRY_MANUAL  = 4'h4;
   localparam int         DXJS_RETRY_TRAY    = 3;

   // paper sizes
   localparam logic [2:0] DXJS_SZ_LTR   = 3'h0;
   localparam logic [2:0] DXJS_SZ_LEGAL = 3'h1;
   localparam logic [2:0] DXJS_SZ_EXEC  = 3'h2;
   localparam logic [2:0] DXJS_SZ_A4    = 3'h3;
   localparam logic [2:0] DXJS_SZ_B5    = 3'h4;

   // print modes, codes 0..4 are duplex-capable
   localparam logic [2:0] DXJS_PM_LAST_DUP = 3'h4;

   // duplex modes: a duplex code is also the number of sheets in flight; simplex allows three
   localparam logic [1:0] DXJS_DM_SIMPLEX = 2'h0;
   localparam logic [1:0] DXJS_DM_SINGLE  = 2'h1;
   localparam logic [1:0] DXJS_DM_ALT     = 2'h3;
   localparam logic [1:0] DXJS_SIMPLEX_FLIGHT = 2'h3;

   // commands over the driver link
   localparam logic DXJS_CMD_REV = 1'b0;
   localparam logic DXJS_CMD_DPK = 1'b1;

   // jam codes
   localparam logic [3:0] DXJS_J_NONE  = 4'h0;
   localparam logic [3:0] DXJS_J_PICK  = 4'h1;
   localparam logic [3:0] DXJS_J_STAY  = 4'h2;
   localparam logic [3:0] DXJS_J_DELV  = 4'h3;
   localparam logic [3:0] DXJS_J_DOOR  = 4'h4;
   localparam logic [3:0] DXJS_J_RESID = 4'h5;
   localparam logic [3:0] DXJS_J_REV1  = 4'h6;
   localparam logic [3:0] DXJS_J_REV2  = 4'h7;
   localparam logic [3:0] DXJS_J_DPK1  = 4'h8;

   typedef enum logic [4:0] {
      DXJS_S_WAIT  = 5'h01,
      DXJS_S_PRINT = 5'h02,
      DXJS_S_HALT  = 5'h04,
      DXJS_S_AUTO  = 5'h08,
      DXJS_S_JAM   = 5'h10
   } dxjs_state_t;

endpackage

// ### pkg/dxjs_tmr_if.sv
// dxjs_tmr_if: start, stop, limit and fire lines of the timer bank.
// assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface dxjs_tmr_if #(
   parameter int N = 9,
   parameter int W = 16
);
   logic [N-1:0]        start;
   logic [N-1:0]        stop;
   logic [N-1:0][W-1:0] limit;
   logic [N-1:0]        fire;

   modport ctl (output start, output stop, output limit, input fire);
   modport tmr (input start, input stop, input limit, output fire);
endinterface
`default_nettype wire

// ### testbench/dxjs_dup_model.sv
// dxjs_dup_model: behavioural duplex driver on the command link.
// assumes the supervisor's clock; lag_i sets how slowly it answers.
`timescale 1ns/1ps
`default_nettype none
module dxjs_dup_model (
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   // command link
   input  wire logic       cmd_valid_i,
   input  wire logic       cmd_kind_i,
   input  wire logic [3:0] lag_i,
   output logic            ready_o,
   output logic            status_valid_o,
   output logic [7:0]      status_o
);
   logic [3:0] wait_q;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_q <= 4'h0;
         ready_o <= 1'h0;
         status_valid_o <= 1'h0;
         status_o <= 8'h00;
      end else begin
         ready_o <= 1'h0;
         status_valid_o <= 1'h0;
         // unqualified status toggles so a stale byte never looks valid
         status_o <= ~status_o;
         if (cmd_valid_i && !ready_o) begin
            wait_q <= (wait_q == lag_i) ? 4'h0 : wait_q + 4'h1;
            ready_o <= (wait_q == lag_i);
         end
         // bit0 deflector, bit1 motor cw, bit2 motor ccw
         if (cmd_valid_i && ready_o) begin
            status_o <= cmd_kind_i ? 8'h04 : 8'h03;
            status_valid_o <= 1'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// testbench: self-checking scenarios for the duplex and jam supervisor.
// assumes dxjs_top with shortened timeouts and the driver model.
`timescale 1ns/1ps
`default_nettype none
module testbench import dxjs_pkg::*;;
   logic ref_clk_i = 0, rst_n_i = 0, clk_en_i = 1, top_of_page_sensor_i = 0;
   logic fuser_exit_sensor_i = 0, output_tray_full_sensor_i = 0, reversal_path_sensor_i = 0;
   logic job_start_i = 0, job_stop_i = 0, page_req_i = 0, auto_deliver_i = 0, jam_clear_i = 0;
   logic dup_cmd_ready_i, dup_status_valid_i, job_reject_o, residual_o, tray_full_o;
   logic interpage_phase_o, jam_o, motors_run_o, pickup_o, dup_cmd_valid_o, dup_cmd_kind_o;
   logic [4:0] door_open_i = 0;
   logic [2:0] paper_size_i = 0, print_mode_i = 0;
   logic [1:0] duplex_mode_i = 0, pickup_source_i = 0;
   logic [7:0] dup_status_i, dup_status_o;
   logic [3:0] jam_code_o, lag = 4'h3;
   int         err_count = 0, n_compared = 0, cycles = 0, n;
   dxjs_top #(.REVC_CYC(10), .DPKC_CYC(10), .PICK_CYC(10), .STAY_CYC(60), .DELV_CYC(60),
      .REV1_CYC(15), .REV2_CYC(20), .DPK1_CYC(20), .AUTO_CYC(20)) dut (.*);
   dxjs_dup_model drv (.ref_clk_i, .rst_n_i, .cmd_valid_i(dup_cmd_valid_o),
      .cmd_kind_i(dup_cmd_kind_o), .lag_i(lag), .ready_o(dup_cmd_ready_i),
      .status_valid_o(dup_status_valid_i), .status_o(dup_status_i));
   always #2.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wrap_up;
      $display("compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task rst;
      @(posedge ref_clk_i);
      rst_n_i <= 0;
      top_of_page_sensor_i <= 0;
      door_open_i <= 0;
      repeat (10) @(posedge ref_clk_i);
      rst_n_i <= 1;
      repeat (6) @(posedge ref_clk_i);
   endtask
   task start(input logic [2:0] sz, pm, input logic [1:0] dm, input logic rej);
      @(posedge ref_clk_i);
      paper_size_i <= sz;
      print_mode_i <= pm;
      duplex_mode_i <= dm;
      job_start_i <= 1;
      @(posedge ref_clk_i);
      job_start_i <= 0;
      @(negedge ref_clk_i);
      chk(job_reject_o, rej);
      chk(motors_run_o, !rej);
      chk(interpage_phase_o, !rej);
   endtask
   task wait_jam;
      repeat (100) begin
         @(negedge ref_clk_i);
         if (jam_o === 1'h1) break;
      end
   endtask
   task page;
      @(posedge ref_clk_i);
      page_req_i <= 1;
      @(posedge ref_clk_i);
      page_req_i <= 0;
   endtask
   task t_reject;
      start(DXJS_SZ_LEGAL, 3'h0, 2'h2, 1'h1);
      start(DXJS_SZ_LEGAL, 3'h0, DXJS_DM_ALT, 1'h1);
      start(3'h5, 3'h0, DXJS_DM_SINGLE, 1'h1);
      start(DXJS_SZ_B5, 3'h5, DXJS_DM_SINGLE, 1'h1);
      start(DXJS_SZ_LEGAL, DXJS_PM_LAST_DUP, DXJS_DM_SINGLE, 1'h0);
   endtask
   task t_pick(input logic [1:0] src, input int exp);
      rst();
      pickup_source_i <= src;
      start(DXJS_SZ_LTR, 3'h0, DXJS_DM_SINGLE, 1'h0);
      page();
      n = 0;
      repeat (200) begin
         @(negedge ref_clk_i);
         if (pickup_o === 1'h1) n++;
         if (jam_o === 1'h1) break;
      end
      chk(8'(n), 8'(exp));
      chk(jam_code_o, DXJS_J_PICK);
      chk(motors_run_o, 1'h0);
   endtask
   task t_door;
      rst();
      start(DXJS_SZ_A4, 3'h1, DXJS_DM_SIMPLEX, 1'h0);
      @(posedge ref_clk_i);
      door_open_i <= 5'h10;
      wait_jam();
      chk(jam_code_o, DXJS_J_DOOR);
      chk(motors_run_o, 1'h0);
   endtask
   task t_rev;
      rst();
      lag <= 4'h1;
      start(DXJS_SZ_LTR, 3'h0, DXJS_DM_SINGLE, 1'h0);
      page();
      @(posedge ref_clk_i);
      top_of_page_sensor_i <= 1;
      n = 0;
      while (dup_cmd_valid_o !== 1'h1 && n < 100) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk(n >= 12 && n <= 20, 1'h1);
      chk(dup_cmd_kind_o, DXJS_CMD_REV);
      wait_jam();
      chk(dup_status_o, 8'h03);
      chk(jam_code_o, DXJS_J_REV1);
   endtask
   task t_resid;
      rst();
      top_of_page_sensor_i <= 1;
      repeat (8) @(negedge ref_clk_i);
      chk(residual_o, 1'h1);
      @(posedge ref_clk_i);
      auto_deliver_i <= 1;
      @(posedge ref_clk_i);
      auto_deliver_i <= 0;
      @(negedge ref_clk_i);
      chk(motors_run_o, 1'h1);
      wait_jam();
      chk(jam_code_o, DXJS_J_RESID);
   endtask
   task t_clear;
      @(posedge ref_clk_i);
      top_of_page_sensor_i <= 0;
      jam_clear_i <= 1;
      repeat (8) @(negedge ref_clk_i);
      chk(jam_o, 1'h0);
      chk(jam_code_o, DXJS_J_NONE);
      @(posedge ref_clk_i);
      fuser_exit_sensor_i <= 1;
      wait_jam();
      chk(jam_code_o, DXJS_J_RESID);
      // frozen clock enable: no clear and no new sensor state
      @(posedge ref_clk_i);
      fuser_exit_sensor_i <= 0;
      output_tray_full_sensor_i <= 1;
      clk_en_i <= 0;
      repeat (8) @(negedge ref_clk_i);
      chk(tray_full_o, 1'h0);
      chk(jam_code_o, DXJS_J_RESID);
      @(posedge ref_clk_i);
      clk_en_i <= 1;
      repeat (8) @(negedge ref_clk_i);
      chk(tray_full_o, 1'h1);
      chk(jam_o, 1'h0);
   endtask
   initial begin
      rst();
      chk(jam_code_o, DXJS_J_NONE);
      t_reject();
      t_pick(DXJS_SRC_MANUAL, 4);
      t_pick(2'h1, DXJS_RETRY_TRAY);
      t_door();
      t_rev();
      t_resid();
      t_clear();
      wrap_up();
   end
endmodule
`default_nettype wire
